// *** src/swf_pkg.sv ***
// Package with constants and types of the status and wake flag bank.
package swf_pkg;
    // Bit positions of the arithmetic flags register.
    localparam int ARITH_CARRY_BIT = 3;
    localparam int ARITH_ZERO_BIT = 2;
    // Bit positions of wake status register A.
    localparam int WSA_PORT_D_BIT = 3;
    localparam int WSA_SUMMARY_BIT = 2;
    localparam int WSA_PORT_C_BIT = 1;
    localparam int WSA_BACKUP_BIT = 0;
    // Bit positions of wake status register B.
    localparam int WSB_PREDIV_BIT = 3;
    localparam int WSB_STAGE15_BIT = 2;
    localparam int WSB_TIMER_ONE_BIT = 1;
    localparam int WSB_EXT_PIN_BIT = 0;
    // Bit positions of wake status register C.
    localparam int WSC_CONVERTER_BIT = 3;
    localparam int WSC_TIMER_TWO_BIT = 1;
    localparam int WSC_KEY_BIT = 0;
    // Bit positions of status register 4.
    localparam int ST4_WRAP_BIT = 2;
    localparam int ST4_WATCHDOG_BIT = 1;
    localparam int ST4_CLOCK_BIT = 0;
    // Operand of the set and reset flag instructions that targets the backup flag.
    localparam logic [7:0] BACKUP_FLAG_OPERAND = 8'h02;
    // Converter mode whose finish signal raises the converter wake request.
    localparam logic [1:0] CONVERTER_FINISH_MODE = 2'h3;
    // Index of each timed wake source in the six-bit request and enable vectors.
    localparam int SRC_TIMER_ONE = 0;
    localparam int SRC_EXT_PIN = 1;
    localparam int SRC_PREDIV = 2;
    localparam int SRC_TIMER_TWO = 3;
    localparam int SRC_KEY = 4;
    localparam int SRC_CONVERTER = 5;
    localparam int NUM_SRC = 6;
    // Reset values.
    localparam logic [3:0] NIBBLE_RESET = 4'h0;
    localparam logic [5:0] SRC_RESET = 6'h00;
    localparam logic CLOCK_SELECT_RESET = 1'b0;
    // Status register selector of a read transfer.
    typedef enum logic [2:0] {
        SWF_SEL_ONE = 3'b000,
        SWF_SEL_TWO = 3'b001,
        SWF_SEL_THREE = 3'b010,
        SWF_SEL_THREE_X = 3'b011,
        SWF_SEL_FOUR = 3'b100
    } swf_sel_e;
endpackage

// *** src/swf_wake_if.sv ***
// Interface carrying the timed wake sources between the bank and its source tracker.
`timescale 1ns/100ps
interface swf_wake_if;
    logic [5:0] raise;
    logic [5:0] clear_req;
    logic en_write;
    logic [5:0] en_value;
    logic [5:0] req;
    logic [5:0] en;
    logic [5:0] flag;
    modport bank (output raise, output clear_req, output en_write, output en_value,
                  input req, input en, input flag);
    modport track (input raise, input clear_req, input en_write, input en_value,
                   output req, output en, output flag);
endinterface

// *** src/swf_wake_track.sv ***
// Halt release requests, enables and start condition flags of the timed sources.
`timescale 1ns/100ps
module swf_wake_track
    import swf_pkg::*;
(
    input wire logic mclk_i,
    input wire logic rstn_i,
    swf_wake_if.track wk
);
    logic [5:0] req_q;
    logic [5:0] en_q;

    // Requests are sticky; a raise wins over a clear in the same cycle.
    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            req_q <= SRC_RESET;
        end else begin
            req_q <= (req_q & ~wk.clear_req) | wk.raise;
        end
    end

    // Halt enables are written whole by the halt enable write instruction.
    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            en_q <= SRC_RESET;
        end else if (wk.en_write) begin
            en_q <= wk.en_value;
        end
    end

    assign wk.req = req_q;
    assign wk.en = en_q;
    // A start condition flag stands while request and enable both stand.
    assign wk.flag = req_q & en_q;

    stat_flags_clear_c: cover property (@(posedge mclk_i) disable iff (!rstn_i)
        $fell(|wk.flag));
endmodule // swf_wake_track

// *** src/swf_bank.sv ***
// Status flag bank: arithmetic flags, wake flags, clock select and watchdog status.
`timescale 1ns/100ps

module swf_bank
    import swf_pkg::*;
(
    input wire logic mclk_i,
    input wire logic rstn_i,
    input wire logic [3:0] work_register_i,
    input wire logic alu_op_i,
    input wire logic alu_carry_i,
    input wire logic read_status_i,
    input wire logic [2:0] read_sel_i,
    input wire logic write_status_one_instr_i,
    input wire logic [3:0] ram_data_i,
    input wire logic port_wake_config_instr_i,
    input wire logic [1:0] port_wake_en_i,
    input wire logic port_c_change_i,
    input wire logic port_d_change_i,
    input wire logic halt_active_i,
    input wire logic halt_instr_i,
    input wire logic set_flag_instr_i,
    input wire logic reset_flag_instr_i,
    input wire logic [7:0] flag_operand_i,
    input wire logic clear_request_instr_i,
    input wire logic [5:0] clear_request_mask_i,
    input wire logic halt_enable_write_instr_i,
    input wire logic [5:0] halt_enable_value_i,
    input wire logic timer_one_underflow_i,
    input wire logic ext_pin_change_i,
    input wire logic prediv_overflow_i,
    input wire logic timer_two_underflow_i,
    input wire logic [3:0] key_input_lines_i,
    input wire logic led_mode_i,
    input wire logic converter_finish_i,
    input wire logic [1:0] converter_mode_i,
    input wire logic prediv_stage15_i,
    input wire logic watchdog_running_i,
    input wire logic converter_counter_wrap_i,
    input wire logic slow_clock_instr_i,
    input wire logic fast_clock_instr_i,
    output logic zero_flag_o,
    output logic [3:0] read_data_o,
    output logic read_valid_o,
    output logic halt_enter_o,
    output logic clock_select_flag_o
);
    swf_wake_if wk ();

    logic carry_flag_q;
    logic zero_flag_q;
    logic port_c_wake_flag_q;
    logic port_d_wake_flag_q;
    logic [1:0] port_wake_en_q;
    logic backup_mode_flag_q;
    logic clock_select_flag_q;
    logic watchdog_on_flag_q;
    logic converter_counter_wrap_flag_q;
    logic [3:0] read_data_q;
    logic read_valid_q;
    logic halt_enter_q;
    logic summary_wake_flag;
    logic any_start_flag;
    logic key_active;
    logic [3:0] arith_flags;
    logic [3:0] wake_status_a;
    logic [3:0] wake_status_b;
    logic [3:0] wake_status_c;
    logic [3:0] status_four;

    // Tests whether a flag instruction names the backup flag.
    function automatic logic is_backup_op(input logic [7:0] op);
        return op == BACKUP_FLAG_OPERAND;
    endfunction

    swf_wake_track u_track (
        .mclk_i(mclk_i),
        .rstn_i(rstn_i),
        .wk(wk.track)
    );

    // Key lines are active high in LED mode and active low in LCD mode.
    assign key_active = led_mode_i ? (|key_input_lines_i) : ~(&key_input_lines_i);

    // Raw requests of the six timed sources.
    always_comb begin
        wk.raise = SRC_RESET;
        wk.raise[SRC_TIMER_ONE] = timer_one_underflow_i;
        wk.raise[SRC_EXT_PIN] = ext_pin_change_i;
        wk.raise[SRC_PREDIV] = prediv_overflow_i;
        wk.raise[SRC_TIMER_TWO] = timer_two_underflow_i;
        wk.raise[SRC_KEY] = key_active;
        wk.raise[SRC_CONVERTER] = converter_finish_i &&
                                  (converter_mode_i == CONVERTER_FINISH_MODE);
    end
    assign wk.clear_req = clear_request_instr_i ? clear_request_mask_i : SRC_RESET;
    assign wk.en_write = halt_enable_write_instr_i;
    assign wk.en_value = halt_enable_value_i;

    // Summary flag of the five sources other than the key.
    assign summary_wake_flag = wk.flag[SRC_EXT_PIN] | wk.flag[SRC_TIMER_ONE] |
                               wk.flag[SRC_TIMER_TWO] | wk.flag[SRC_PREDIV] |
                               wk.flag[SRC_CONVERTER];
    assign any_start_flag = (|wk.flag) | port_c_wake_flag_q | port_d_wake_flag_q;

    // Register images assembled from the live flags.
    always_comb begin
        arith_flags = NIBBLE_RESET;
        arith_flags[ARITH_CARRY_BIT] = carry_flag_q;
        arith_flags[ARITH_ZERO_BIT] = zero_flag_q;
        wake_status_a = NIBBLE_RESET;
        wake_status_a[WSA_PORT_D_BIT] = port_d_wake_flag_q;
        wake_status_a[WSA_SUMMARY_BIT] = summary_wake_flag;
        wake_status_a[WSA_PORT_C_BIT] = port_c_wake_flag_q;
        wake_status_a[WSA_BACKUP_BIT] = backup_mode_flag_q;
        wake_status_b = NIBBLE_RESET;
        wake_status_b[WSB_PREDIV_BIT] = wk.flag[SRC_PREDIV];
        wake_status_b[WSB_STAGE15_BIT] = prediv_stage15_i;
        wake_status_b[WSB_TIMER_ONE_BIT] = wk.flag[SRC_TIMER_ONE];
        wake_status_b[WSB_EXT_PIN_BIT] = wk.flag[SRC_EXT_PIN];
        wake_status_c = NIBBLE_RESET;
        wake_status_c[WSC_CONVERTER_BIT] = wk.flag[SRC_CONVERTER];
        wake_status_c[WSC_TIMER_TWO_BIT] = wk.flag[SRC_TIMER_TWO];
        wake_status_c[WSC_KEY_BIT] = wk.flag[SRC_KEY];
        status_four = NIBBLE_RESET;
        status_four[ST4_WRAP_BIT] = converter_counter_wrap_flag_q;
        status_four[ST4_WATCHDOG_BIT] = watchdog_on_flag_q;
        status_four[ST4_CLOCK_BIT] = clock_select_flag_q;
    end

    // Zero flag tracks the work register one cycle later.
    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            zero_flag_q <= 1'b1;
        end else begin
            zero_flag_q <= (work_register_i == NIBBLE_RESET);
        end
    end

    // Carry is loaded by arithmetic, or from RAM bit 3 by the write transfer.
    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            carry_flag_q <= 1'b0;
        end else if (alu_op_i) begin
            carry_flag_q <= alu_carry_i;
        end else if (write_status_one_instr_i) begin
            carry_flag_q <= ram_data_i[ARITH_CARRY_BIT];
        end
    end

    // Port wake enables and flags; the config instruction clears both flags.
    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            port_wake_en_q <= 2'h0;
            port_c_wake_flag_q <= 1'b0;
            port_d_wake_flag_q <= 1'b0;
        end else begin
            if (port_wake_config_instr_i) begin
                port_wake_en_q <= port_wake_en_i;
            end
            // Set wins over the clear by the config instruction.
            port_c_wake_flag_q <= (port_c_wake_flag_q & ~port_wake_config_instr_i) |
                                  (port_c_change_i & port_wake_en_q[0] &
                                   halt_active_i);
            port_d_wake_flag_q <= (port_d_wake_flag_q & ~port_wake_config_instr_i) |
                                  (port_d_change_i & port_wake_en_q[1] &
                                   halt_active_i);
        end
    end

    // Backup flag driven by the flag instructions.
    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            backup_mode_flag_q <= 1'b0;
        end else if (set_flag_instr_i && is_backup_op(flag_operand_i)) begin
            backup_mode_flag_q <= 1'b1;
        end else if (reset_flag_instr_i && is_backup_op(flag_operand_i)) begin
            backup_mode_flag_q <= 1'b0;
        end
    end

    // Clock select flag follows the slow and fast instructions.
    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            clock_select_flag_q <= CLOCK_SELECT_RESET;
        end else if (fast_clock_instr_i) begin
            clock_select_flag_q <= 1'b1;
        end else if (slow_clock_instr_i) begin
            clock_select_flag_q <= 1'b0;
        end
    end

    // Sampled status of watchdog and converter counter.
    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            watchdog_on_flag_q <= 1'b0;
            converter_counter_wrap_flag_q <= 1'b0;
        end else begin
            watchdog_on_flag_q <= watchdog_running_i;
            converter_counter_wrap_flag_q <= converter_counter_wrap_i;
        end
    end

    // Read transfers return the selected register one cycle later.
    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            read_data_q <= NIBBLE_RESET;
            read_valid_q <= 1'b0;
        end else begin
            read_valid_q <= read_status_i;
            if (read_status_i) begin
                case (read_sel_i)
                    SWF_SEL_ONE: read_data_q <= arith_flags;
                    SWF_SEL_TWO: read_data_q <= wake_status_a;
                    SWF_SEL_THREE: read_data_q <= wake_status_b;
                    SWF_SEL_THREE_X: read_data_q <= wake_status_c;
                    SWF_SEL_FOUR: read_data_q <= status_four;
                    default: read_data_q <= NIBBLE_RESET;
                endcase
            end
        end
    end

    // The halt instruction halts only when no start condition flag stands.
    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            halt_enter_q <= 1'b0;
        end else begin
            halt_enter_q <= halt_instr_i & ~any_start_flag;
        end
    end

    assign zero_flag_o = zero_flag_q;
    assign read_data_o = read_data_q;
    assign read_valid_o = read_valid_q;
    assign halt_enter_o = halt_enter_q;
    assign clock_select_flag_o = clock_select_flag_q;

    // Checks next to the logic they guard.
    zero_track_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        ##1 zero_flag_o == ($past(work_register_i) == 4'h0))
        else $error("zero flag does not follow work register");
    carry_load_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        alu_op_i |=> carry_flag_q == $past(alu_carry_i))
        else $error("carry not captured");
    write_one_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        (write_status_one_instr_i && !alu_op_i) |=> carry_flag_q == $past(ram_data_i[3]))
        else $error("write transfer carry wrong");
    summary_or_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        summary_wake_flag == (wake_status_b[0] | wake_status_b[1] | wake_status_b[3] |
                              wake_status_c[1] | wake_status_c[3]))
        else $error("summary flag not OR of sources");
    halt_block_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        (halt_instr_i && any_start_flag) |=> !halt_enter_o)
        else $error("halt entered with start flag set");
    backup_set_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        (set_flag_instr_i && flag_operand_i == 8'h02) |=> backup_mode_flag_q)
        else $error("backup flag not set");
    port_c_clr_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        (port_wake_config_instr_i && !(port_c_change_i && halt_active_i))
        |=> !port_c_wake_flag_q)
        else $error("port c flag not cleared");
    ext_pin_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        (ext_pin_change_i && !halt_enable_write_instr_i && wk.en[SRC_EXT_PIN])
        |=> wk.flag[SRC_EXT_PIN] ##0 wake_status_b[0])
        else $error("external pin flag not set");
    clock_sel_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        (slow_clock_instr_i && !fast_clock_instr_i) |=> !clock_select_flag_o)
        else $error("clock select not cleared");
    read_four_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        (read_status_i && read_sel_i == 3'b100) |=> read_valid_o && !read_data_o[3])
        else $error("status four bit 3 not zero");

    halt_refused_c: cover property (@(posedge mclk_i) disable iff (!rstn_i)
        halt_instr_i && any_start_flag);
    halt_taken_c: cover property (@(posedge mclk_i) disable iff (!rstn_i)
        halt_instr_i ##1 halt_enter_o);
    summary_rise_c: cover property (@(posedge mclk_i) disable iff (!rstn_i)
        $rose(summary_wake_flag));
endmodule // swf_bank

// *** bench/swf_core_model.sv ***
// Behavioural processor core that enters and leaves halt mode around the flag bank.
`timescale 1ns/100ps
module swf_core_model (
    input wire logic mclk_i,
    input wire logic rstn_i,
    input wire logic halt_enter_i,
    input wire logic wake_i,
    output logic halt_active_o
);
    // Halt starts on an accepted halt and ends on any wake event; the bank sees it at that edge.
    always_ff @(posedge mclk_i) begin
        if (!rstn_i || wake_i) begin
            halt_active_o <= 1'b0;
        end else if (halt_enter_i) begin
            halt_active_o <= 1'b1;
        end
    end
endmodule // swf_core_model

// *** bench/swf_bank_test.sv ***
// Self-checking testbench of the status and wake flag bank.
`timescale 1ns/100ps
module swf_bank_test
    import swf_pkg::*;
;
    localparam int RD = 0, WR1 = 1, PCFG = 2, HLT = 3, SETF = 4, RSTF = 5, CLRQ = 6, HEW = 7;
    localparam int SLOW = 8, FAST = 9, ALU = 10, EV = 11, PCC = 17, NONE = 31;
    typedef struct packed {
        logic [3:0] acc; logic cy; logic fast; logic wd; logic wrap;
        logic [3:0] arith; logic [3:0] st4;
    } swf_row_s;
    // Bench-driven inputs; st holds every one-cycle strobe and event pulse.
    logic mclk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic [3:0] work_register_i = 4'h0;
    logic alu_carry_i = 1'b0;
    logic [2:0] read_sel_i = 3'h0;
    logic [3:0] ram_data_i = 4'h0;
    logic [1:0] port_wake_en_i = 2'h0;
    logic [7:0] flag_operand_i = 8'h00;
    logic [5:0] clear_request_mask_i = 6'h00;
    logic [5:0] halt_enable_value_i = 6'h00;
    logic watchdog_running_i = 1'b0;
    logic converter_counter_wrap_i = 1'b0;
    logic led_mode_i = 1'b1;
    logic [1:0] converter_mode_i = 2'h3;
    logic prediv_stage15_i = 1'b1;
    logic [31:0] st = 32'h0;
    logic halt_active_i;
    logic zero_flag_o, read_valid_o, halt_enter_o, clock_select_flag_o;
    logic [3:0] read_data_o;
    int failures = 0;
    int n_tests = 0;
    // Ordinary cases: accumulator, carry, clock and watchdog inputs beside expected images.
    swf_row_s rows [5] = '{'{4'h0, 1'b1, 1'b1, 1'b1, 1'b0, 4'hc, 4'h3},
                           '{4'h1, 1'b0, 1'b0, 1'b0, 1'b1, 4'h0, 4'h4},
                           '{4'hf, 1'b1, 1'b0, 1'b1, 1'b1, 4'h8, 4'h6},
                           '{4'h8, 1'b0, 1'b1, 1'b0, 1'b0, 4'h0, 4'h1},
                           '{4'h0, 1'b0, 1'b0, 1'b0, 1'b0, 4'h4, 4'h0}};
    // Register and expected image of each timed source; stage 15 input is high here.
    swf_sel_e src_sel [6] = '{SWF_SEL_THREE, SWF_SEL_THREE, SWF_SEL_THREE,
                              SWF_SEL_THREE_X, SWF_SEL_THREE_X, SWF_SEL_THREE_X};
    logic [3:0] src_exp [6] = '{4'h6, 4'h5, 4'hc, 4'h2, 4'h1, 4'h8};

    swf_bank i_swf_bank (
        .mclk_i, .rstn_i, .work_register_i, .alu_op_i(st[ALU]), .alu_carry_i,
        .read_status_i(st[RD]), .read_sel_i, .write_status_one_instr_i(st[WR1]), .ram_data_i,
        .port_wake_config_instr_i(st[PCFG]), .port_wake_en_i, .port_c_change_i(st[PCC]),
        .port_d_change_i(st[PCC + 1]), .halt_active_i, .halt_instr_i(st[HLT]),
        .set_flag_instr_i(st[SETF]), .reset_flag_instr_i(st[RSTF]), .flag_operand_i,
        .clear_request_instr_i(st[CLRQ]), .clear_request_mask_i,
        .halt_enable_write_instr_i(st[HEW]), .halt_enable_value_i,
        .timer_one_underflow_i(st[EV + SRC_TIMER_ONE]), .ext_pin_change_i(st[EV + SRC_EXT_PIN]),
        .prediv_overflow_i(st[EV + SRC_PREDIV]), .timer_two_underflow_i(st[EV + SRC_TIMER_TWO]),
        .key_input_lines_i({4{~led_mode_i}} ^ {1'b0, st[EV + SRC_KEY], 2'b00}), .led_mode_i,
        .converter_finish_i(st[EV + SRC_CONVERTER]), .converter_mode_i,
        .prediv_stage15_i, .watchdog_running_i, .converter_counter_wrap_i,
        .slow_clock_instr_i(st[SLOW]), .fast_clock_instr_i(st[FAST]),
        .zero_flag_o, .read_data_o, .read_valid_o, .halt_enter_o, .clock_select_flag_o);

    swf_core_model i_swf_core_model (
        .mclk_i, .rstn_i, .halt_enter_i(halt_enter_o), .wake_i(|st[18:11]),
        .halt_active_o(halt_active_i));

    // Clock of 5 ns period.
    always #2.5 mclk_i = ~mclk_i;

    task automatic chk(input string nm, input logic [3:0] exp, input logic [3:0] got);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // Raises up to two strobes for one cycle, launched and dropped at falling edges.
    task automatic go(input int k, input int k2 = NONE);
        @(negedge mclk_i);
        st[k] = 1'b1;
        st[k2] = 1'b1;
        @(negedge mclk_i);
        st = 32'h0;
    endtask

    task automatic rd(input logic [2:0] sel, input logic [3:0] exp, input string nm);
        read_sel_i = sel;
        go(RD);
        chk("read valid", 4'h1, {3'h0, read_valid_o});
        chk(nm, exp, read_data_o);
    endtask

    task automatic halt_try(input logic exp, input string nm);
        go(HLT);
        chk(nm, {3'h0, exp}, {3'h0, halt_enter_o});
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Watchdog that cuts a hang short.
    initial begin
        repeat (5000) @(posedge mclk_i);
        failures++;
        print_verdict();
    end

    // Main sequence.
    initial begin
        repeat (12) @(negedge mclk_i);
        chk("reset outputs", 4'h8,
            {zero_flag_o, read_valid_o, halt_enter_o, clock_select_flag_o});
        rstn_i = 1'b1;
        rd(SWF_SEL_TWO, 4'h0, "reset image a");
        rd(SWF_SEL_THREE, 4'h4, "reset image b");
        rd(SWF_SEL_THREE_X, 4'h0, "reset image c");
        halt_try(1'b1, "halt after reset");
        foreach (rows[i]) begin
            work_register_i = rows[i].acc;
            alu_carry_i = rows[i].cy;
            watchdog_running_i = rows[i].wd;
            converter_counter_wrap_i = rows[i].wrap;
            go(ALU, rows[i].fast ? FAST : SLOW);
            chk("zero flag", {3'h0, rows[i].arith[2]}, {3'h0, zero_flag_o});
            chk("clock select", {3'h0, rows[i].fast}, {3'h0, clock_select_flag_o});
            rd(SWF_SEL_ONE, rows[i].arith, "arith flags");
            rd(SWF_SEL_FOUR, rows[i].st4, "status four");
        end
        // Only the carry is writable; an arithmetic carry in the same cycle wins.
        ram_data_i = 4'hf;
        go(WR1);
        rd(SWF_SEL_ONE, 4'hc, "carry write");
        alu_carry_i = 1'b0;
        go(ALU, WR1);
        rd(SWF_SEL_ONE, 4'h4, "carry priority");
        rd(3'h5, 4'h0, "spare selector");
        flag_operand_i = BACKUP_FLAG_OPERAND;
        go(SETF);
        rd(SWF_SEL_TWO, 4'h1, "backup set");
        go(RSTF);
        rd(SWF_SEL_TWO, 4'h0, "backup clear");
        // Each timed source: ignored when disabled, flagged when enabled, then cleared (even indices) or disabled again (odd indices).
        for (int k = 0; k < NUM_SRC; k++) begin
            halt_enable_value_i = 6'h00;
            go(HEW);
            go(EV + k);
            rd(src_sel[k], 4'h4 & src_exp[k], "disabled source");
            halt_enable_value_i = 6'(1 << k);
            go(HEW);
            go(EV + k);
            rd(src_sel[k], src_exp[k], "source flag");
            rd(SWF_SEL_TWO, {1'b0, k != SRC_KEY, 2'b00}, "summary flag");
            halt_try(1'b0, "halt refused");
            halt_enable_value_i = 6'h00;
            clear_request_mask_i = 6'(1 << k);
            go(k[0] ? HEW : CLRQ);
            rd(src_sel[k], 4'h4 & src_exp[k], "source clear");
            rd(SWF_SEL_TWO, 4'h0, "summary clear");
            halt_try(1'b1, "halt accepted");
        end
        // Stage 15 is live; another converter mode and idle LCD key lines raise nothing.
        prediv_stage15_i = 1'b0;
        clear_request_mask_i = 6'h3f;
        go(CLRQ);
        rd(SWF_SEL_THREE, 4'h0, "stage 15 low");
        prediv_stage15_i = 1'b1;
        halt_enable_value_i = 6'h30;
        go(HEW);
        converter_mode_i = 2'h1;
        led_mode_i = 1'b0;
        go(EV + SRC_CONVERTER);
        rd(SWF_SEL_THREE_X, 4'h0, "other mode and idle keys");
        go(EV + SRC_KEY);
        rd(SWF_SEL_THREE_X, 4'h1, "lcd key active");
        converter_mode_i = 2'h3;
        led_mode_i = 1'b1;
        go(CLRQ);
        // Port C then port D: a change counts only while halted.
        for (int p = 0; p < 2; p++) begin
            port_wake_en_i = 2'(2 >> p);
            go(PCFG);
            halt_try(1'b1, "halt entry disabled port");
            go(PCC + p);
            rd(SWF_SEL_TWO, 4'h0, "port disabled");
            port_wake_en_i = 2'h3;
            go(PCFG);
            halt_try(1'b1, "halt entry");
            go(PCC + p);
            rd(SWF_SEL_TWO, p ? 4'h8 : 4'h2, "port flag");
            halt_try(1'b0, "port halt refused");
            go(PCFG);
            rd(SWF_SEL_TWO, 4'h0, "port clear");
            go(PCC + p);
            rd(SWF_SEL_TWO, 4'h0, "port change awake");
        end
        // A reset in mid-run clears flags, sticky requests and the clock select.
        halt_enable_value_i = 6'h3f;
        go(HEW);
        go(EV + SRC_EXT_PIN, FAST);
        rstn_i = 1'b0;
        repeat (2) @(negedge mclk_i);
        rstn_i = 1'b1;
        rd(SWF_SEL_THREE, 4'h4, "flags after reset");
        halt_try(1'b1, "halt after second reset");
        chk("clock after reset", 4'h0, {3'h0, clock_select_flag_o});
        print_verdict();
    end
endmodule // swf_bank_test
